// >>> inc/retry_swap_pkg.sv
// register map, field layout, reset values and codes of the retry and compare-swap block
package retry_swap_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned UNITS  = 3;

  // byte addresses of the words on the register bus
  localparam logic [7:0] RETRY_LIMITS_OFFSET = 8'h08;
  localparam logic [7:0] SWAP_DATA_OFFSET    = 8'h0C;
  localparam logic [7:0] SWAP_COMPARE_OFFSET = 8'h10;
  localparam logic [7:0] SWAP_CONTROL_OFFSET = 8'h14;
  localparam logic [7:0] EVENT_STATUS_OFFSET = 8'h40;
  localparam logic [7:0] EVENT_MASK_OFFSET   = 8'h44;

  // retry limit word: unit u owns bits [4u+3:4u], u = 0 request, 1 response, 2 physical
  localparam int unsigned RETRY_FIELD_W   = 4;
  localparam int unsigned RETRY_USED_W    = 12;
  localparam int unsigned DUAL_SECOND_LSB = 29;
  localparam int unsigned DUAL_CYCLE_LSB  = 16;
  localparam int unsigned UNIT_REQUEST    = 0;
  localparam int unsigned UNIT_RESPONSE   = 1;
  localparam int unsigned UNIT_PHYSICAL   = 2;
  localparam logic [11:0] RETRY_LIMITS_RESET = 12'h000;

  // swap control word
  localparam int unsigned SWAP_DONE_BIT = 31;
  localparam int unsigned SWAP_SEL_W    = 2;
  localparam logic        SWAP_DONE_RESET = 1'b1;
  localparam logic [1:0]  SWAP_SEL_RESET  = 2'h0;

  // resource selector codes
  localparam logic [1:0] SEL_BUS_MANAGER_ID        = 2'h0;
  localparam logic [1:0] SEL_BANDWIDTH_AVAILABLE   = 2'h1;
  localparam logic [1:0] SEL_CHANNELS_AVAILABLE_HI = 2'h2;
  localparam logic [1:0] SEL_CHANNELS_AVAILABLE_LO = 2'h3;

  // resource contents after reset
  localparam logic [31:0] BUS_MANAGER_ID_RESET        = 32'h0000003F;
  localparam logic [31:0] BANDWIDTH_AVAILABLE_RESET   = 32'h00001333;
  localparam logic [31:0] CHANNELS_AVAILABLE_HI_RESET = 32'hFFFFFFFF;
  localparam logic [31:0] CHANNELS_AVAILABLE_LO_RESET = 32'hFFFFFFFF;

  // event status / mask layout
  localparam int unsigned EVENT_W         = 4;
  localparam int unsigned EVENT_SWAP_DONE = 0;
  localparam int unsigned EVENT_GIVEUP_LSB = 1;
  localparam logic [3:0]  EVENT_RESET     = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SWAP_IDLE,
    SWAP_RUN
  } swap_state_e;

endpackage : retry_swap_pkg

// >>> logic/retry_swap_regs.sv
// transmit retry limits, compare-swap on bus management resources, axi4-lite slave
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/10ps

// Contract
// - second-limit field bits 31-29 read zero
// - cycle-limit field bits 28-16 read zero
// - bits 15-12 of retry word read zero
// - physical response unit retries up to limit
// - transmit response unit retries up to limit
// - transmit request unit retries up to limit
// - swap data holds value to store
// - swap compare holds value to compare
// - swap control selects resource, starts operation
// - done flag set when swap finishes
// - any swap control write clears done
// - swap control bits 30-2 read zero
// - selector codes map to four resources
module retry_swap_regs (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [2:0]  tx_start,
  input  wire logic [2:0]  tx_ack_retryable,
  output logic [2:0]       tx_retry,
  output logic [2:0]       tx_give_up,
  output logic [31:0]      bus_manager_id,
  output logic [31:0]      bandwidth_available,
  output logic [31:0]      channels_available_hi,
  output logic [31:0]      channels_available_lo,
  output logic             irq
);

  logic [7:0]  aw_addr_reg;
  logic        aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_held_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;

  logic [11:0] retry_limits_reg;
  logic [31:0] swap_data_reg;
  logic [31:0] swap_compare_reg;
  logic [1:0]  swap_sel_reg;
  logic        swap_done_reg;
  logic [31:0] resource_reg [4];
  retry_swap_pkg::swap_state_e swap_state_reg;

  logic [3:0]  event_status_reg;
  logic [3:0]  event_mask_reg;
  logic [3:0]  event_set;
  logic [3:0]  event_clear;

  logic [2:0]  give_up_next;
  logic        write_fire;
  logic        read_fire;
  logic        write_mapped;
  logic        read_mapped;
  logic        launch;
  logic        swap_finish;
  logic [31:0] swap_old;
  logic [31:0] read_word;

  // a write waits while a swap runs, so the swap never races a register update
  assign write_fire = aw_held_reg && w_held_reg && !bvalid_reg
                      && (swap_state_reg == retry_swap_pkg::SWAP_IDLE);
  assign read_fire  = s_axi_arvalid && s_axi_arready;
  assign launch     = write_fire && (aw_addr_reg == retry_swap_pkg::SWAP_CONTROL_OFFSET);
  assign swap_finish = (swap_state_reg == retry_swap_pkg::SWAP_RUN);
  assign swap_old   = resource_reg[swap_sel_reg];

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready  = !w_held_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  assign bus_manager_id        = resource_reg[retry_swap_pkg::SEL_BUS_MANAGER_ID];
  assign bandwidth_available   = resource_reg[retry_swap_pkg::SEL_BANDWIDTH_AVAILABLE];
  assign channels_available_hi = resource_reg[retry_swap_pkg::SEL_CHANNELS_AVAILABLE_HI];
  assign channels_available_lo = resource_reg[retry_swap_pkg::SEL_CHANNELS_AVAILABLE_LO];

  always_comb begin
    case (aw_addr_reg)
      retry_swap_pkg::RETRY_LIMITS_OFFSET,
      retry_swap_pkg::SWAP_DATA_OFFSET,
      retry_swap_pkg::SWAP_COMPARE_OFFSET,
      retry_swap_pkg::SWAP_CONTROL_OFFSET,
      retry_swap_pkg::EVENT_STATUS_OFFSET,
      retry_swap_pkg::EVENT_MASK_OFFSET: write_mapped = 1'b1;
      default:                           write_mapped = 1'b0;
    endcase
  end

  // write address and data channels, taken in either order
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (write_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (write_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= retry_swap_pkg::RESP_OKAY;
    end else if (write_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= write_mapped ? retry_swap_pkg::RESP_OKAY : retry_swap_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // read mux: unused fields and reserved bits are constant zero
  always_comb begin
    read_mapped = 1'b1;
    read_word   = 32'h00000000;
    case (s_axi_araddr)
      retry_swap_pkg::RETRY_LIMITS_OFFSET:
        read_word = {20'h00000, retry_limits_reg};
      retry_swap_pkg::SWAP_DATA_OFFSET:
        read_word = swap_data_reg;
      retry_swap_pkg::SWAP_COMPARE_OFFSET:
        read_word = swap_compare_reg;
      retry_swap_pkg::SWAP_CONTROL_OFFSET:
        read_word = {swap_done_reg, 29'h00000000, swap_sel_reg};
      retry_swap_pkg::EVENT_STATUS_OFFSET:
        read_word = {28'h0000000, event_status_reg};
      retry_swap_pkg::EVENT_MASK_OFFSET:
        read_word = {28'h0000000, event_mask_reg};
      default:
        read_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= retry_swap_pkg::RESP_OKAY;
      rdata_reg  <= 32'h00000000;
    end else if (read_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= read_mapped ? retry_swap_pkg::RESP_OKAY : retry_swap_pkg::RESP_SLVERR;
      rdata_reg  <= read_word;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // retry limit fields, byte-lane writes
  always_ff @(posedge clk) begin
    if (reset) begin
      retry_limits_reg <= retry_swap_pkg::RETRY_LIMITS_RESET;
    end else if (write_fire && aw_addr_reg == retry_swap_pkg::RETRY_LIMITS_OFFSET) begin
      if (w_strb_reg[0]) begin
        retry_limits_reg[7:0] <= w_data_reg[7:0];
      end
      if (w_strb_reg[1]) begin
        retry_limits_reg[11:8] <= w_data_reg[11:8];
      end
    end
  end

  // software loads compare; data is loaded by software and overwritten by the swap
  always_ff @(posedge clk) begin
    if (reset) begin
      swap_compare_reg <= 32'h00000000;
    end else if (write_fire && aw_addr_reg == retry_swap_pkg::SWAP_COMPARE_OFFSET) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_reg[b]) begin
          swap_compare_reg[8*b +: 8] <= w_data_reg[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      swap_data_reg <= 32'h00000000;
    end else if (swap_finish) begin
      swap_data_reg <= swap_old;
    end else if (write_fire && aw_addr_reg == retry_swap_pkg::SWAP_DATA_OFFSET) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_reg[b]) begin
          swap_data_reg[8*b +: 8] <= w_data_reg[8*b +: 8];
        end
      end
    end
  end

  // control: selector, done flag and the one-cycle swap engine
  always_ff @(posedge clk) begin
    if (reset) begin
      swap_sel_reg <= retry_swap_pkg::SWAP_SEL_RESET;
    end else if (launch && w_strb_reg[0]) begin
      swap_sel_reg <= w_data_reg[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      swap_done_reg <= retry_swap_pkg::SWAP_DONE_RESET;
    end else if (swap_finish) begin
      swap_done_reg <= 1'b1;
    end else if (launch) begin
      swap_done_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      swap_state_reg <= retry_swap_pkg::SWAP_IDLE;
    end else begin
      case (swap_state_reg)
        retry_swap_pkg::SWAP_IDLE: begin
          if (launch) begin
            swap_state_reg <= retry_swap_pkg::SWAP_RUN;
          end
        end
        retry_swap_pkg::SWAP_RUN: begin
          swap_state_reg <= retry_swap_pkg::SWAP_IDLE;
        end
        default: begin
          swap_state_reg <= retry_swap_pkg::SWAP_IDLE;
        end
      endcase
    end
  end

  // compare and store happen in one edge, so nothing can see a half-done swap
  always_ff @(posedge clk) begin
    if (reset) begin
      resource_reg[retry_swap_pkg::SEL_BUS_MANAGER_ID] <=
        retry_swap_pkg::BUS_MANAGER_ID_RESET;
      resource_reg[retry_swap_pkg::SEL_BANDWIDTH_AVAILABLE] <=
        retry_swap_pkg::BANDWIDTH_AVAILABLE_RESET;
      resource_reg[retry_swap_pkg::SEL_CHANNELS_AVAILABLE_HI] <=
        retry_swap_pkg::CHANNELS_AVAILABLE_HI_RESET;
      resource_reg[retry_swap_pkg::SEL_CHANNELS_AVAILABLE_LO] <=
        retry_swap_pkg::CHANNELS_AVAILABLE_LO_RESET;
    end else if (swap_finish && swap_old == swap_compare_reg) begin
      resource_reg[swap_sel_reg] <= swap_data_reg;
    end
  end

  // per-unit retry counters; limit zero means no retry at all
  generate
    for (genvar u = 0; u < retry_swap_pkg::UNITS; u++) begin : g_unit
      logic [3:0] tries_reg;
      logic [3:0] limit;
      logic       retry_reg;

      assign limit = retry_limits_reg[4*u +: 4];

      always_ff @(posedge clk) begin
        if (reset) begin
          tries_reg <= 4'h0;
        end else if (tx_start[u]) begin
          tries_reg <= 4'h0;
        end else if (tx_ack_retryable[u] && tries_reg < limit) begin
          tries_reg <= tries_reg + 4'h1;
        end
      end

      always_ff @(posedge clk) begin
        if (reset) begin
          retry_reg <= 1'b0;
        end else begin
          retry_reg <= !tx_start[u] && tx_ack_retryable[u] && (tries_reg < limit);
        end
      end

      assign give_up_next[u] = !tx_start[u] && tx_ack_retryable[u] && (tries_reg >= limit);
      assign tx_retry[u]     = retry_reg;
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_give_up <= 3'h0;
    end else begin
      tx_give_up <= give_up_next;
    end
  end

  // sticky events; a set in the clearing read's cycle survives the read
  assign event_set   = {give_up_next, swap_finish};
  assign event_clear = (read_fire && s_axi_araddr == retry_swap_pkg::EVENT_STATUS_OFFSET)
                       ? event_status_reg : 4'h0;

  always_ff @(posedge clk) begin
    if (reset) begin
      event_status_reg <= retry_swap_pkg::EVENT_RESET;
    end else begin
      event_status_reg <= (event_status_reg & ~event_clear) | event_set;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      event_mask_reg <= retry_swap_pkg::EVENT_RESET;
    end else if (write_fire && aw_addr_reg == retry_swap_pkg::EVENT_MASK_OFFSET
                 && w_strb_reg[0]) begin
      event_mask_reg <= w_data_reg[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((event_status_reg & ~event_clear) | event_set) & event_mask_reg);
    end
  end

endmodule : retry_swap_regs

// >>> test/retry_swap_partner.sv
// transmit-unit partner: starts packets and returns busy or data-error acks
`timescale 1ns/10ps
module retry_swap_partner (
  input  wire logic clk,
  output logic [2:0] tx_start,
  output logic [2:0] tx_ack_retryable
);
  initial begin
    tx_start         = 3'h0;
    tx_ack_retryable = 3'h0;
  end

  // one-cycle pulses, launched just after an edge so the design samples them once
  task automatic pulse(input logic [2:0] st, input logic [2:0] ack);
    @(posedge clk);
    tx_start         <= st;
    tx_ack_retryable <= ack;
    @(posedge clk);
    tx_start         <= 3'h0;
    tx_ack_retryable <= 3'h0;
    #1;
  endtask : pulse
endmodule : retry_swap_partner

// >>> test/retry_swap_checker.sv
// concurrent checks on the retry and compare-swap register block ports
`timescale 1ns/10ps
module retry_swap_checker (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [2:0]  tx_start,
  input wire logic [2:0]  tx_ack_retryable,
  input wire logic [2:0]  tx_retry,
  input wire logic [2:0]  tx_give_up,
  input wire logic [31:0] bus_manager_id,
  input wire logic [31:0] bandwidth_available,
  input wire logic [31:0] channels_available_hi,
  input wire logic [31:0] channels_available_lo
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  ack_answer_a: assert property (
    (tx_retry | tx_give_up) == ($past(tx_ack_retryable) & ~$past(tx_start)))
    else $error("ack not answered by one retry or give-up");
  retry_excl_a: assert property ((tx_retry & tx_give_up) == 3'h0)
    else $error("retry and give-up together");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped early");
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not inverse of rvalid");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  aw_taken_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address slot not held");
  // resources move only from a host swap, never on their own
  swap_commit_a: assert property (
    $changed(bus_manager_id) || $changed(bandwidth_available) ||
    $changed(channels_available_hi) || $changed(channels_available_lo) |->
    $past(s_axi_bvalid))
    else $error("resource changed without a swap");

  cover property (|tx_give_up);
  cover property (|tx_retry);
  cover property ($changed(bus_manager_id));
endmodule : retry_swap_checker

bind retry_swap_regs retry_swap_checker checker_u (.clk, .reset, .s_axi_awvalid, .s_axi_awready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_start, .tx_ack_retryable, .tx_retry,
  .tx_give_up, .bus_manager_id, .bandwidth_available, .channels_available_hi,
  .channels_available_lo);

// >>> test/retry_swap_regs_tb.sv
// self-checking bench for the retry limit and compare-swap registers
`timescale 1ns/10ps
module retry_swap_regs_tb;
  logic        clk, reset, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d, nv, bm, bw, ch, cl;
  logic [1:0]  bresp, rresp, rs;
  logic [2:0]  tx_start, tx_ack, tx_retry, tx_give_up;
  logic [3:0]  wstrb, strb_sel;
  logic [31:0] res [4];
  int          num_errors, cmp_count, cycles, lim;

  retry_swap_partner partner_u (.clk(clk), .tx_start(tx_start), .tx_ack_retryable(tx_ack));
  retry_swap_regs dut_u (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_start(tx_start),
    .tx_ack_retryable(tx_ack), .tx_retry(tx_retry), .tx_give_up(tx_give_up),
    .bus_manager_id(bm), .bandwidth_available(bw), .channels_available_hi(ch),
    .channels_available_lo(cl), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // handshakes judged at the falling edge, so they reflect what the rising edge samples
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    logic aw_hs, w_hs, b_hs;
    @(posedge clk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    wstrb <= strb_sel;
    b_hs = 1'b0;
    while (!b_hs) begin
      @(negedge clk);
      aw_hs = awvalid && awready;
      w_hs  = wvalid && wready;
      b_hs  = bvalid;
      r     = bresp;
      @(posedge clk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    #1;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    logic ar_hs, r_hs;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge clk);
      ar_hs = arvalid && arready;
      r_hs  = rvalid;
      v     = rdata;
      r     = rresp;
      @(posedge clk);
      if (ar_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    #1;
  endtask : axi_read

  function automatic logic [31:0] res_out(input int i);
    return (i == 0) ? bm : (i == 1) ? bw : (i == 2) ? ch : cl;
  endfunction : res_out

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  initial begin
    reset = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    wstrb = 4'hF;
    strb_sel = 4'hF;
    res[0] = retry_swap_pkg::BUS_MANAGER_ID_RESET;
    res[1] = retry_swap_pkg::BANDWIDTH_AVAILABLE_RESET;
    res[2] = retry_swap_pkg::CHANNELS_AVAILABLE_HI_RESET;
    res[3] = retry_swap_pkg::CHANNELS_AVAILABLE_LO_RESET;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    axi_read(retry_swap_pkg::RETRY_LIMITS_OFFSET, d, rs);
    check("retry reset", d, 32'h00000000);
    axi_read(retry_swap_pkg::SWAP_CONTROL_OFFSET, d, rs);
    check("control reset", d, 32'h80000000);
    axi_write(retry_swap_pkg::RETRY_LIMITS_OFFSET, 32'hFFFFFFFF, rs);
    axi_read(retry_swap_pkg::RETRY_LIMITS_OFFSET, d, rs);
    check("retry ro bits", d, 32'h00000FFF);
    // lane 1 alone clears only the physical response field
    strb_sel = 4'h2;
    axi_write(retry_swap_pkg::RETRY_LIMITS_OFFSET, 32'h00000000, rs);
    strb_sel = 4'hF;
    axi_read(retry_swap_pkg::RETRY_LIMITS_OFFSET, d, rs);
    check("retry lane 1", d, 32'h000000FF);
    axi_read(8'h80, d, rs);
    check("unmapped read", {rs, d[29:0]}, {retry_swap_pkg::RESP_SLVERR, 30'h0});
    axi_write(8'h80, 32'h1, rs);
    check("unmapped write", {30'h0, rs}, {30'h0, retry_swap_pkg::RESP_SLVERR});
    $display("register map test done");
    // per resource: a matching swap, then a refused one on the new value
    for (int i = 0; i < 4; i++) begin
      nv = 32'hA5A50000 | i;
      axi_write(retry_swap_pkg::SWAP_DATA_OFFSET, nv, rs);
      axi_write(retry_swap_pkg::SWAP_COMPARE_OFFSET, res[i], rs);
      axi_read(retry_swap_pkg::SWAP_COMPARE_OFFSET, d, rs);
      check("compare", d, res[i]);
      axi_write(retry_swap_pkg::SWAP_CONTROL_OFFSET, 32'h7FFFFFFC | i, rs);
      axi_read(retry_swap_pkg::SWAP_CONTROL_OFFSET, d, rs);
      check("control done", d, 32'h80000000 | i);
      axi_read(retry_swap_pkg::SWAP_DATA_OFFSET, d, rs);
      check("old value", d, res[i]);
      res[i] = nv;
      check("swapped", res_out(i), res[i]);
      // fresh data value, so a wrongly taken swap would show on the resource
      axi_write(retry_swap_pkg::SWAP_DATA_OFFSET, nv ^ 32'h00FF0000, rs);
      axi_write(retry_swap_pkg::SWAP_COMPARE_OFFSET, ~nv, rs);
      axi_write(retry_swap_pkg::SWAP_CONTROL_OFFSET, i, rs);
      axi_read(retry_swap_pkg::SWAP_DATA_OFFSET, d, rs);
      check("refused old", d, nv);
      check("refused kept", res_out(i), res[i]);
    end
    $display("compare-swap test done");
    check("irq masked", {31'h0, irq}, 32'h0);
    axi_write(retry_swap_pkg::EVENT_MASK_OFFSET, 32'hF, rs);
    check("irq unmasked", {31'h0, irq}, 32'h1);
    axi_read(retry_swap_pkg::EVENT_MASK_OFFSET, d, rs);
    check("mask readback", d, 32'h0000000F);
    axi_read(retry_swap_pkg::EVENT_STATUS_OFFSET, d, rs);
    check("status swap", d, 32'h1);
    @(posedge clk);
    #1;
    check("irq cleared", {31'h0, irq}, 32'h0);
    // limits: request 3, response 2, physical 1
    axi_write(retry_swap_pkg::RETRY_LIMITS_OFFSET, 32'h00000123, rs);
    for (int u = 0; u < 3; u++) begin
      lim = 3 - u;
      partner_u.pulse(3'h1 << u, 3'h1 << u);
      check("start wins", {26'h0, tx_retry, tx_give_up}, 32'h0);
      for (int k = 0; k <= lim; k++) begin
        partner_u.pulse(3'h0, 3'h1 << u);
        check("retry", {29'h0, tx_retry}, (k < lim) ? (32'h1 << u) : 32'h0);
        check("give up", {29'h0, tx_give_up}, (k == lim) ? (32'h1 << u) : 32'h0);
      end
    end
    @(posedge clk);
    #1;
    check("irq give up", {31'h0, irq}, 32'h1);
    axi_read(retry_swap_pkg::EVENT_STATUS_OFFSET, d, rs);
    check("status give up", d, 32'hE);
    $display("retry test done");
    test_done();
  end
endmodule : retry_swap_regs_tb
